// File: pkg/sch_pkg.sv
// Package of constants and carrier types for the speech codec homing control.
package sch_pkg;
	localparam int FRAME_SAMPLES = 160;
	localparam int SAMPLE_W = 16;
	localparam int NUM_MODES = 8;
	localparam int MODE_W = 3;
	localparam int PARAM_W = 244;
	localparam int LENGTH_W = 8;
	localparam int SAMPLE_CNT_W = 8;
	localparam logic [SAMPLE_W-1:0] ENC_HOME_SAMPLE = 16'h0008;
	localparam logic [SAMPLE_CNT_W-1:0] LAST_SAMPLE = 8'h9f;
	localparam logic [LENGTH_W-1:0] MODE_LENGTH [NUM_MODES] = '{8'h5f, 8'h67, 8'h76, 8'h86, 8'h94, 8'h9f, 8'hcc,
		8'hf4};
	localparam logic [LENGTH_W-1:0] MODE_EARLY_LENGTH [NUM_MODES] = '{8'h30, 8'h2e, 8'h33, 8'h37, 8'h3a, 8'h3b,
		8'h48, 8'h53};

	// One speech sample with its frame-start mark.
	typedef struct packed {
		logic first;
		logic [SAMPLE_W-1:0] sample;
	} sch_sample_s;

	// One decoder parameter frame in the active mode, first bit in the top position.
	typedef struct packed {
		logic [PARAM_W-1:0] bits;
	} sch_param_s;

	// Encoder side frame states.
	typedef enum logic [1:0] {
		ENC_IDLE,
		ENC_RUN,
		ENC_ODD
	} sch_enc_state_e;
endpackage

// File: rtl/sch_skid.sv
`timescale 1ns/1ns
// Two-entry buffer with valid and ready on both sides.
module sch_skid
	import sch_pkg::*;
#(
	parameter int WIDTH = SAMPLE_W + 1
)
(
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Filling side.
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side.
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] mem_q [2];
	logic [WIDTH-1:0] mem_d [2];
	logic [WIDTH-1:0] head_q, head_d;
	logic [1:0] count_q, count_d;
	logic rd_q, rd_d, wr_q, wr_d;
	logic in_ready_q, in_ready_d, out_valid_q, out_valid_d;
	logic push, pop;

	// A word narrower than one bit cannot be stored, so elaboration stops here.
	if (WIDTH < 1)
	begin : g_bad_width
		$error("sch_skid width must be positive");
	end

	// Next pointers, count and storage.
	always_comb
	begin
		push = in_valid && in_ready_q;
		pop = out_valid_q && out_ready;
		mem_d = mem_q;
		if (push)
			mem_d[wr_q] = in_data;
		wr_d = wr_q ^ push;
		rd_d = rd_q ^ pop;
		count_d = count_q + 2'(push) - 2'(pop);
		// Flags and head word are registered so that every output leaves a flip-flop.
		head_d = mem_d[rd_d];
		in_ready_d = count_d != 2'h2;
		out_valid_d = count_d != 2'h0;
	end

	// Registers of the buffer.
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			count_q <= 2'h0;
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			mem_q <= '{default: '0};
			head_q <= '0;
			in_ready_q <= 1'b1;
			out_valid_q <= 1'b0;
		end
		else
		begin
			count_q <= count_d;
			rd_q <= rd_d;
			wr_q <= wr_d;
			mem_q <= mem_d;
			head_q <= head_d;
			in_ready_q <= in_ready_d;
			out_valid_q <= out_valid_d;
		end
	end

	assign in_ready = in_ready_q;
	assign out_valid = out_valid_q;
	assign out_data = head_q;
endmodule

// File: rtl/sch_homing.sv
`timescale 1ns/1ns
// Homing frame detection, output substitution and home reset control for the speech codec.
// Contract
// - Encoder homing frame is 160 equal 13-bit samples holding only the low bit.
// - Left-justified 16-bit samples are compared against word 0008 hex.
// - One encoder homing pattern serves all modes, for detection and substitution.
// - Eight decoder homing patterns exist; the current mode selects one.
// - Encoder homing counts only when the pattern fills exactly one aligned frame.
// - Encoder processes a homing frame normally and emits its parameter frame.
// - From home state, encoder output for a homing frame equals the decoder pattern.
// - After an encoder homing frame all encoder sub-modules return home.
// - Decoder homes only on the current mode's pattern, never other modes'.
// - Decoder from home state replaces its output with the encoder homing frame.
// - After a decoder homing frame all decoder sub-modules, noise generator too, return home.
// - Back-to-back decoder homing frames yield encoder homing output from the second on.
// - In home state the decoder may check only early parameters.
// - Reset loads the codec mode externally and sets all state to initial values.
module sch_homing
	import sch_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Codec mode loaded at reset.
	input wire logic [MODE_W-1:0] reset_mode,
	// Encoder input samples from the source.
	input wire logic enc_in_valid,
	output logic enc_in_ready,
	input wire sch_sample_s enc_in,
	// Encoder samples toward the encoder datapath.
	output logic enc_out_valid,
	input wire logic enc_out_ready,
	output sch_sample_s enc_out,
	// Encoder homing reset, pulsed after a homing frame ends.
	output logic enc_home_reset,
	output logic enc_home_q_out,
	// Decoder parameter frame input, one frame per strobe.
	input wire logic dec_frame_valid,
	input wire sch_param_s dec_frame,
	input wire sch_param_s dec_home_table [NUM_MODES],
	// Decoder synthesis completion and substitution control.
	input wire logic dec_synth_done,
	output logic dec_substitute,
	output logic [SAMPLE_W-1:0] dec_subst_sample,
	output logic dec_home_reset,
	output logic [MODE_W-1:0] codec_mode
);
	sch_sample_s skid_data;
	logic skid_valid, skid_ready;
	sch_enc_state_e enc_state_q, enc_state_d;
	logic [SAMPLE_CNT_W-1:0] cnt_q, cnt_d;
	logic match_q, match_d;
	logic enc_home_q, enc_home_d;
	logic enc_rst_q, enc_rst_d;
	logic dec_home_q, dec_home_d;
	logic dec_hit_q, dec_hit_d;
	logic dec_sub_q, dec_sub_d;
	logic dec_rst_q, dec_rst_d;
	logic dec_pend_q, dec_pend_d;
	logic [MODE_W-1:0] mode_q, mode_d;
	logic [SAMPLE_W-1:0] dec_word_q, dec_word_d;
	logic mode_load_q;
	logic dec_full_match, dec_early_match, take;
	logic [PARAM_W-1:0] pattern, early_mask, full_mask;

	// Stall-safe buffer in front of the encoder datapath.
	sch_skid #(.WIDTH($bits(sch_sample_s))) u_skid (
		.clk(clk),
		.reset(reset),
		.in_valid(enc_in_valid),
		.in_ready(enc_in_ready),
		.in_data(enc_in),
		.out_valid(skid_valid),
		.out_ready(skid_ready),
		.out_data(skid_data)
	);

	// Mode follows the external source while reset is high and one edge after, then holds.
	always_comb
	begin
		mode_d = (reset || mode_load_q) ? reset_mode : mode_q;
	end

	// Mode registers.
	always_ff @(posedge clk)
	begin
		mode_load_q <= reset;
		mode_q <= mode_d;
	end

	// Decoder pattern selection by mode and reduced comparison window.
	always_comb
	begin
		pattern = dec_home_table[mode_q].bits;
		early_mask = ~({PARAM_W{1'b1}} >> MODE_EARLY_LENGTH[mode_q]);
		// Padding below the mode's frame length is never compared, so stale bits there cannot block homing.
		full_mask = ~({PARAM_W{1'b1}} >> MODE_LENGTH[mode_q]);
		dec_full_match = ((dec_frame.bits ^ pattern) & full_mask) == '0;
		dec_early_match = ((dec_frame.bits ^ pattern) & early_mask) == '0;
	end

	// Encoder frame alignment and homing detection.
	always_comb
	begin
		take = skid_valid && skid_ready;
		enc_state_d = enc_state_q;
		cnt_d = cnt_q;
		match_d = match_q;
		enc_home_d = enc_home_q;
		enc_rst_d = 1'b0;
		if (take)
		begin
			if (skid_data.first)
			begin
				cnt_d = '0;
				match_d = skid_data.sample == ENC_HOME_SAMPLE;
				enc_state_d = ENC_RUN;
			end
			else if (enc_state_q == ENC_RUN)
			begin
				cnt_d = cnt_q + 8'h01;
				match_d = match_q && (skid_data.sample == ENC_HOME_SAMPLE);
			end
			else
			begin
				enc_state_d = ENC_ODD; // Samples before an aligned start never home
				enc_home_d = 1'b0; // A misaligned frame is not a homing frame
			end
			if (enc_state_d == ENC_RUN && cnt_d == LAST_SAMPLE)
			begin
				// Frame passes through normally first, then home reset follows
				enc_rst_d = match_d;
				enc_home_d = match_d;
				enc_state_d = ENC_IDLE;
			end
		end
	end

	// Encoder side registers.
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			enc_state_q <= ENC_IDLE;
			cnt_q <= '0;
			match_q <= 1'b0;
			enc_home_q <= 1'b1;
			enc_rst_q <= 1'b0;
		end
		else
		begin
			enc_state_q <= enc_state_d;
			cnt_q <= cnt_d;
			match_q <= match_d;
			enc_home_q <= enc_home_d;
			enc_rst_q <= enc_rst_d;
		end
	end

	// Decoder homing: detect and substitute on the frame strobe, then reset home after synthesis.
	always_comb
	begin
		dec_home_d = dec_home_q;
		dec_hit_d = dec_hit_q;
		dec_sub_d = dec_sub_q;
		dec_pend_d = dec_pend_q;
		dec_rst_d = 1'b0;
		dec_word_d = ENC_HOME_SAMPLE;
		if (dec_synth_done && dec_pend_q)
		begin
			dec_rst_d = dec_hit_q;
			dec_home_d = dec_hit_q;
			dec_pend_d = 1'b0;
		end
		// A frame in the same cycle starts from the state the finished frame leaves, so no homing is lost.
		if (dec_frame_valid)
		begin
			dec_hit_d = dec_home_d ? dec_early_match : dec_full_match;
			dec_sub_d = dec_home_d && dec_hit_d;
			dec_pend_d = 1'b1;
		end
	end

	// Decoder side registers.
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			dec_home_q <= 1'b1;
			dec_hit_q <= 1'b0;
			dec_sub_q <= 1'b0;
			dec_rst_q <= 1'b0;
			dec_pend_q <= 1'b0;
			dec_word_q <= ENC_HOME_SAMPLE;
		end
		else
		begin
			dec_home_q <= dec_home_d;
			dec_hit_q <= dec_hit_d;
			dec_sub_q <= dec_sub_d;
			dec_rst_q <= dec_rst_d;
			dec_pend_q <= dec_pend_d;
			dec_word_q <= dec_word_d;
		end
	end

	// Encoder output skid: the buffer head is the registered sample.
	assign skid_ready = enc_out_ready;
	assign enc_out_valid = skid_valid;
	assign enc_out = skid_data;
	assign enc_home_reset = enc_rst_q;
	assign enc_home_q_out = enc_home_q;
	assign dec_substitute = dec_sub_q;
	assign dec_subst_sample = dec_word_q;
	assign dec_home_reset = dec_rst_q;
	assign codec_mode = mode_q;
endmodule

// File: verif/sch_homing_properties.sv
// Concurrent checks on the ports of the homing control.
`timescale 1ns/1ns
module sch_homing_properties
	import sch_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Encoder side.
	input wire logic enc_out_valid,
	input wire logic enc_out_ready,
	input wire sch_sample_s enc_out,
	input wire logic enc_home_reset,
	input wire logic enc_home_q_out,
	// Decoder side.
	input wire logic dec_frame_valid,
	input wire logic dec_synth_done,
	input wire logic dec_substitute,
	input wire logic [SAMPLE_W-1:0] dec_subst_sample,
	input wire logic dec_home_reset,
	input wire logic [MODE_W-1:0] codec_mode
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_subst_word: assert property (dec_subst_sample == 16'h0008) else $error("substitute word wrong");
	a_enc_pulse_one: assert property (enc_home_reset |=> !enc_home_reset) else $error("encoder pulse long");
	a_enc_after_take: assert property (enc_home_reset |-> $past(enc_out_valid && enc_out_ready))
		else $error("encoder pulse without last sample");
	a_enc_home_set: assert property (enc_home_reset |-> ##[0:1] enc_home_q_out) else $error("home flag not set");
	a_stall_hold: assert property (enc_out_valid && !enc_out_ready |=> enc_out_valid && $stable(enc_out))
		else $error("sample lost in stall");
	a_sub_cause: assert property ($changed(dec_substitute) |-> $past(dec_frame_valid))
		else $error("substitute moved without frame");
	a_dec_rst_cause: assert property (dec_home_reset |-> $past(dec_synth_done) && !$past(dec_home_reset))
		else $error("decoder home reset unexpected");
	a_mode_hold: assert property (!$past(reset) && !$past(reset, 2) |-> $stable(codec_mode))
		else $error("mode moved");
	c_enc_home: cover property (enc_home_reset);
	c_dec_sub: cover property ($rose(dec_substitute));
	c_dec_home: cover property (dec_home_reset);
	c_stall: cover property (enc_out_valid && !enc_out_ready);
endmodule

// File: verif/sch_far_model.sv
// Far side model: encoder datapath with stalls and decoder synthesis timing.
`timescale 1ns/1ns
module sch_far_model
	import sch_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Sample sink and decoder synthesis.
	input wire logic dec_frame_valid,
	output logic enc_out_ready = 1'b0,
	output logic dec_synth_done = 1'b0
);
	logic [1:0] pipe_q = 2'b00;
	// Stalls the sink at random and reports synthesis three cycles after each frame.
	always @(posedge clk)
	begin
		enc_out_ready <= reset ? 1'b0 : ($urandom() % 4) != 0;
		pipe_q <= reset ? 2'b00 : {pipe_q[0], dec_frame_valid};
		dec_synth_done <= !reset && pipe_q[1];
	end
endmodule

// File: verif/tb.sv
// Self-checking bench for the homing control.
`timescale 1ns/1ns
`define CHK(n, e, s) \
	begin \
		n_compared++; \
		if ((s) !== (e)) \
		begin \
			err_total++; \
			$display("unexpected %s expected %h seen %h", n, e, s); \
		end \
	end
module tb
	import sch_pkg::*;
;
	logic clk = 0, reset = 1, enc_in_valid = 0, enc_in_ready, enc_out_valid, enc_out_ready, enc_home_reset;
	logic enc_home_q_out, dec_frame_valid = 0, dec_synth_done, dec_substitute, dec_home_reset;
	logic [MODE_W-1:0] reset_mode = '0, codec_mode;
	logic [SAMPLE_W-1:0] dec_subst_sample;
	sch_sample_s enc_in = '0, enc_out;
	sch_param_s dec_frame = '0, tbl [NUM_MODES];
	int err_total = 0, n_compared = 0, n_ehr = 0, n_dhr = 0, mode;
	bit home;
	sch_sample_s exp_q [$];
	sch_sample_s exp_s;
	sch_homing dut_u (
		.clk(clk),
		.reset(reset),
		.reset_mode(reset_mode),
		.enc_in_valid(enc_in_valid),
		.enc_in_ready(enc_in_ready),
		.enc_in(enc_in),
		.enc_out_valid(enc_out_valid),
		.enc_out_ready(enc_out_ready),
		.enc_out(enc_out),
		.enc_home_reset(enc_home_reset),
		.enc_home_q_out(enc_home_q_out),
		.dec_frame_valid(dec_frame_valid),
		.dec_frame(dec_frame),
		.dec_home_table(tbl),
		.dec_synth_done(dec_synth_done),
		.dec_substitute(dec_substitute),
		.dec_subst_sample(dec_subst_sample),
		.dec_home_reset(dec_home_reset),
		.codec_mode(codec_mode)
	);
	sch_far_model far_u (
		.clk(clk),
		.reset(reset),
		.dec_frame_valid(dec_frame_valid),
		.enc_out_ready(enc_out_ready),
		.dec_synth_done(dec_synth_done)
	);
	always #5 clk = ~clk;
	// Counts the home reset pulses of both sides.
	always @(posedge clk)
	begin
		n_ehr += (enc_home_reset === 1'b1);
		n_dhr += (dec_home_reset === 1'b1);
	end
	// Reference of the sample path: every accepted word leaves once, in order and unchanged.
	always @(posedge clk)
	begin
		if (reset)
			exp_q.delete();
		else
		begin
			if (enc_in_valid && enc_in_ready === 1'b1)
				exp_q.push_back(enc_in);
			if (enc_out_valid === 1'b1 && enc_out_ready === 1'b1)
			begin
				if (exp_q.size() == 0)
				begin
					`CHK("enc_out_valid", 1'b0, enc_out_valid)
				end
				else
				begin
					exp_s = exp_q.pop_front();
					`CHK("enc_out", exp_s, enc_out)
				end
			end
		end
	end
	function automatic sch_param_s rnd();
		sch_param_s f;
		for (int i = 0; i < 8; i++)
			f.bits = {f.bits[PARAM_W-33:0], 32'($urandom())};
		return f;
	endfunction
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic do_reset(input int m);
		reset <= 1'b1;
		reset_mode <= m[MODE_W-1:0];
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		home = 1;
		repeat (2) @(posedge clk);
		`CHK("codec_mode", m[MODE_W-1:0], codec_mode)
	endtask
	task automatic dec_send(input sch_param_s f);
		logic m;
		int base;
		logic [PARAM_W-1:0] d;
		d = f.bits ^ tbl[mode].bits;
		// In home state only the early parameters count; otherwise the whole frame of the mode.
		if (home)
			m = (d >> (PARAM_W - int'(MODE_EARLY_LENGTH[mode]))) == '0;
		else
			m = (d >> (PARAM_W - int'(MODE_LENGTH[mode]))) == '0;
		base = n_dhr;
		dec_frame_valid <= 1'b1;
		dec_frame <= f;
		@(posedge clk);
		dec_frame_valid <= 1'b0;
		@(negedge clk);
		`CHK("dec_substitute", home && m, dec_substitute)
		`CHK("dec_subst_sample", ENC_HOME_SAMPLE, dec_subst_sample)
		home = m;
		repeat (8) @(posedge clk);
		`CHK("dec_home_reset", int'(m), n_dhr - base)
	endtask
	task automatic enc_frame(input logic f, input logic [15:0] s0, input logic [15:0] s, input int e);
		int base;
		base = n_ehr;
		for (int i = 0; i < FRAME_SAMPLES; i++)
		begin
			enc_in_valid <= 1'b1;
			enc_in <= '{first: f && i == 0, sample: i == 0 ? s0 : s};
			do @(negedge clk); while (enc_in_ready !== 1'b1);
			@(posedge clk);
		end
		enc_in_valid <= 1'b0;
		repeat (30) @(posedge clk);
		`CHK("enc_home_reset", e, n_ehr - base)
		`CHK("enc_home_q_out", e, enc_home_q_out)
	endtask
	// Main sequence: every mode on the decoder side, then encoder frames.
	initial
	begin
		void'($urandom(32'h5f1360d4));
		foreach (tbl[k])
			tbl[k] = rnd();
		for (int m = 0; m < NUM_MODES; m++)
		begin
			mode = m;
			do_reset(m);
			dec_send(rnd());
			dec_send(tbl[m]);
			dec_send(tbl[m]);
			dec_send(tbl[m] ^ {{(PARAM_W - 1){1'b0}}, 1'b1});
			dec_send(tbl[(m + 1) % NUM_MODES]);
			$display("test decoder mode %0d done", m);
		end
		enc_frame(1, 16'h0008, 16'h0008, 1);
		enc_frame(1, 16'h0008, 16'h0008, 1);
		enc_frame(0, 16'h0008, 16'h0008, 0);
		enc_frame(1, 16'h0018, 16'h0008, 0);
		enc_frame(1, 16'h0008, 16'($urandom_range(16'h0009, 16'hffff)), 0);
		`CHK("enc_out_pending", 0, exp_q.size())
		$display("test encoder done");
		results();
	end
	// Cuts a hang short.
	initial
	begin
		#400000;
		err_total++;
		results();
	end
endmodule
bind sch_homing sch_homing_properties chk_u (
	.clk(clk),
	.reset(reset),
	.enc_out_valid(enc_out_valid),
	.enc_out_ready(enc_out_ready),
	.enc_out(enc_out),
	.enc_home_reset(enc_home_reset),
	.enc_home_q_out(enc_home_q_out),
	.dec_frame_valid(dec_frame_valid),
	.dec_synth_done(dec_synth_done),
	.dec_substitute(dec_substitute),
	.dec_subst_sample(dec_subst_sample),
	.dec_home_reset(dec_home_reset),
	.codec_mode(codec_mode)
);
